/* File: src/apc_pkg.sv */
// package: register map, encodings and constants of the power/export/overrange controller
package apc_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int NUM_VC = 8;

    localparam logic [15:0] REG_EXPORT_GATE = 16'h0008;
    localparam logic [15:0] REG_PDN_CTRL_A = 16'h003f;
    localparam logic [15:0] REG_PDN_CTRL_B = 16'h0040;
    localparam logic [15:0] REG_OVR_CLEAR = 16'h0562;
    localparam logic [15:0] REG_OVR_STATUS = 16'h0563;
    localparam logic [15:0] REG_STBY_FILL = 16'h0571;
    localparam logic [15:0] REG_REF_EXPORT = 16'h18a6;
    localparam logic [15:0] REG_VCM_EXPORT = 16'h18e3;
    localparam logic [15:0] REG_DIODE_SEL = 16'h18e6;

    // power-down control field in either control register
    localparam int PDN_MODE_LSB = 0;
    localparam logic [1:0] PDN_MODE_PIN = 2'h0;
    localparam logic [1:0] PDN_MODE_PWRDN = 2'h1;
    localparam logic [1:0] PDN_MODE_STBY = 2'h2;
    // control register b: pin function, 0 = power-down, 1 = standby
    localparam int PIN_FUNC_BIT = 2;
    localparam int STBY_K_BIT = 7;

    localparam logic [7:0] DIODE_OFF = 8'h00;
    localparam logic [7:0] DIODE_SMALL = 8'h01;
    localparam logic [7:0] DIODE_LARGE = 8'h02;
    localparam logic [7:0] GATE_ON = 8'h01;
    localparam logic [7:0] EXPORT_OFF = 8'h00;
    localparam logic [7:0] K_CHAR = 8'hbc;

    // controller's own AXI registers (byte addresses)
    localparam logic [7:0] AXI_CMD = 8'h00;
    localparam logic [7:0] AXI_WDATA = 8'h04;
    localparam logic [7:0] AXI_RDATA = 8'h08;
    localparam logic [7:0] AXI_IRQ_STAT = 8'h0c;
    localparam logic [7:0] AXI_IRQ_MASK = 8'h10;
    localparam logic [7:0] AXI_OVR_SHADOW = 8'h14;
    localparam int CMD_WR_BIT = 16;
    localparam int CMD_RD_BIT = 17;
    localparam int CMD_DIODE_BIT = 18;
    localparam int CMD_CLR_BIT = 19;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVR = 1;

    typedef enum logic [1:0] {APC_LINK_UP, APC_LINK_STBY, APC_LINK_DOWN} apc_link_e;
endpackage

/* File: src/apc_if.sv */
// interface: register port and link between controller and converter
`timescale 1ns/1ns
interface apc_if;
    import apc_pkg::*;
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic link_valid;
    logic [13:0] sample;
    logic ctrl_ovr;
    logic k_char;
    modport device (input req, we, addr, wdata, output ack, rdata, link_valid, sample, ctrl_ovr, k_char);
    modport host (output req, we, addr, wdata, input ack, rdata, link_valid, sample, ctrl_ovr, k_char);
endinterface

/* File: src/apc_delay.sv */
// module: fixed-length pipeline that keeps the overrange flag aligned with its sample
`timescale 1ns/1ns
module apc_delay #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    import apc_pkg::*;
    logic [WIDTH-1:0] pipe_q [DEPTH];

    if (DEPTH < 1) begin
        $error("depth must be at least one");
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) pipe_q[i] <= '0;
        end else begin
            pipe_q[0] <= d_i;
            for (int i = 1; i < DEPTH; i++) pipe_q[i] <= pipe_q[i-1];
        end
    end

    assign q_o = pipe_q[DEPTH-1];
endmodule

/* File: src/apc_device.sv */
// module: converter end - power-down/standby, voltage export select, overrange flags
//
// Functional notes
// - pin active high, defaults to power-down
// - power-down drops the output link
// - registers 0x3f/0x40 also command power-down
// - standby keeps link, sends zero samples
// - 0x571 bit7 sends K characters instead
// - 0x18e6: 1 small diode, 2 large
// - host sets gate, clears vcm, ref first
// - host enables one export at once; only the diode command enforces it, plain writes do not
// - overrange flag follows input overrange
// - flag rides as control bit when enabled
// - flag delayed like sample path
// - sticky per-converter bits at 0x563
// - set-then-reset in 0x562 clears bit
`timescale 1ns/1ns
module apc_device #(
    parameter int PIPE_DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    apc_if.device bus,
    input wire logic power_down_standby_pin_i,
    input wire logic [13:0] sample_i,
    input wire logic [apc_pkg::NUM_VC-1:0] vc_overrange_i,
    input wire logic [1:0] control_bits_per_sample_i,
    output logic [1:0] vref_source_o,
    output logic vref_conflict_o,
    output apc_pkg::apc_link_e link_state_o
);
    import apc_pkg::*;

    logic pin_s1_q, pin_s2_q;
    logic [7:0] gate_q, pdn_a_q, pdn_b_q, clr_q, fill_q, ref_q, vcm_q, diode_q, sticky_q;
    logic [7:0] clr_prev_q;
    logic ack_q;
    logic [7:0] rdata_q;
    logic [14:0] pipe_in, pipe_out;
    apc_link_e state_q;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= power_down_standby_pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ------------------------------------------------------------
    // register port: one-cycle ack after req
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gate_q <= 8'h00;
            pdn_a_q <= 8'h00;
            pdn_b_q <= 8'h00;
            clr_q <= 8'h00;
            fill_q <= 8'h00;
            ref_q <= 8'h00;
            vcm_q <= 8'h00;
            diode_q <= 8'h00;
        end else if (bus.req && bus.we && !ack_q) begin
            case (bus.addr)
                REG_EXPORT_GATE: gate_q <= bus.wdata;
                REG_PDN_CTRL_A: pdn_a_q <= bus.wdata;
                REG_PDN_CTRL_B: pdn_b_q <= bus.wdata;
                REG_OVR_CLEAR: clr_q <= bus.wdata;
                REG_STBY_FILL: fill_q <= bus.wdata;
                REG_REF_EXPORT: ref_q <= bus.wdata;
                REG_VCM_EXPORT: vcm_q <= bus.wdata;
                REG_DIODE_SEL: diode_q <= bus.wdata;
                default: ;
            endcase
        end
    end

    function automatic logic [7:0] read_reg(input logic [15:0] a);
        case (a)
            REG_EXPORT_GATE: read_reg = gate_q;
            REG_PDN_CTRL_A: read_reg = pdn_a_q;
            REG_PDN_CTRL_B: read_reg = pdn_b_q;
            REG_OVR_CLEAR: read_reg = clr_q;
            REG_OVR_STATUS: read_reg = sticky_q;
            REG_STBY_FILL: read_reg = fill_q;
            REG_REF_EXPORT: read_reg = ref_q;
            REG_VCM_EXPORT: read_reg = vcm_q;
            REG_DIODE_SEL: read_reg = diode_q;
            default: read_reg = 8'h00;
        endcase
    endfunction

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ack_q <= bus.req && !ack_q;
            if (bus.req && !ack_q && !bus.we) rdata_q <= read_reg(bus.addr);
        end
    end
    assign bus.ack = ack_q;
    assign bus.rdata = rdata_q;

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    function automatic logic [1:0] pdn_mode(input logic [7:0] r);
        pdn_mode = r[PDN_MODE_LSB +: 2];
    endfunction

    apc_link_e state_d;
    always_comb begin
        state_d = APC_LINK_UP;
        // register command takes precedence over the pin
        if (pdn_mode(pdn_a_q) == PDN_MODE_PWRDN || pdn_mode(pdn_b_q) == PDN_MODE_PWRDN) begin
            state_d = APC_LINK_DOWN;
        end else if (pdn_mode(pdn_a_q) == PDN_MODE_STBY || pdn_mode(pdn_b_q) == PDN_MODE_STBY) begin
            state_d = APC_LINK_STBY;
        end else if (pin_s2_q) begin
            // pin defaults to power-down unless standby is selected
            state_d = pdn_b_q[PIN_FUNC_BIT] ? APC_LINK_STBY : APC_LINK_DOWN;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) state_q <= APC_LINK_UP;
        else state_q <= state_d;
    end
    assign link_state_o = state_q;

    // ------------------------------------------------------------
    // sample / overrange path
    // ------------------------------------------------------------
    assign pipe_in = {|vc_overrange_i, sample_i};
    apc_delay #(.WIDTH(15), .DEPTH(PIPE_DEPTH)) u_delay (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(pipe_in),
        .q_o(pipe_out)
    );

    logic link_valid_q, ctrl_ovr_q, k_q;
    logic [13:0] sample_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_valid_q <= 1'b0;
            sample_q <= 14'h0000;
            ctrl_ovr_q <= 1'b0;
            k_q <= 1'b0;
        end else begin
            case (state_q)
                APC_LINK_DOWN: begin
                    link_valid_q <= 1'b0;
                    sample_q <= 14'h0000;
                    ctrl_ovr_q <= 1'b0;
                    k_q <= 1'b0;
                end
                APC_LINK_STBY: begin
                    link_valid_q <= 1'b1;
                    ctrl_ovr_q <= 1'b0;
                    k_q <= fill_q[STBY_K_BIT];
                    sample_q <= fill_q[STBY_K_BIT] ? {6'h00, K_CHAR} : 14'h0000;
                end
                default: begin
                    link_valid_q <= 1'b1;
                    k_q <= 1'b0;
                    sample_q <= pipe_out[13:0];
                    ctrl_ovr_q <= (control_bits_per_sample_i != 2'h0) && pipe_out[14];
                end
            endcase
        end
    end
    assign bus.link_valid = link_valid_q;
    assign bus.sample = sample_q;
    assign bus.ctrl_ovr = ctrl_ovr_q;
    assign bus.k_char = k_q;

    // ------------------------------------------------------------
    // sticky overrange status, cleared on falling edge of clear bit
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clr_prev_q <= 8'h00;
            sticky_q <= 8'h00;
        end else begin
            clr_prev_q <= clr_q;
            for (int n = 0; n < NUM_VC; n++) begin
                // set beats the clear in the same cycle
                if (vc_overrange_i[n]) sticky_q[n] <= 1'b1;
                else if (clr_prev_q[n] && !clr_q[n]) sticky_q[n] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // reference pin export
    // ------------------------------------------------------------
    always_comb begin
        case (diode_q)
            DIODE_SMALL: vref_source_o = 2'h1;
            DIODE_LARGE: vref_source_o = 2'h2;
            default: vref_source_o = 2'h0;
        endcase
    end
    // output undefined if more than one source drives the pin
    assign vref_conflict_o = (vref_source_o != 2'h0) && (ref_q != EXPORT_OFF || vcm_q != EXPORT_OFF);
endmodule

/* File: src/apc_host.sv */
// module: controller end - AXI4-Lite slave that drives the register port
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module apc_host (
    input wire logic clk_i,
    input wire logic rst_n_i,
    apc_if.host bus,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq_o
);
    import apc_pkg::*;
    typedef enum {H_IDLE, H_SEQ, H_WAIT} apc_hst_e;

    logic aw_q, w_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [31:0] cmd_q;
    logic [7:0] rd_q, ovr_q, mask_q, data_q;
    logic [1:0] stat_q;
    logic ev_done, ev_ovr;
    apc_hst_e st_q;
    logic [2:0] step_q, nsteps_q;
    logic req_q, we_q;
    logic [15:0] addr_q;
    logic [7:0] wd_q;
    logic [7:0] clr_bits_q;

    // ------------------------------------------------------------
    // axi write path
    // ------------------------------------------------------------
    wire wr_fire = aw_q && w_q && !s_axi_bvalid;
    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;
    assign s_axi_bresp = 2'h0;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_q) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_q) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire cmd_go = wr_fire && awaddr_q == AXI_CMD && st_q == H_IDLE;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_q <= 32'h0;
            mask_q <= 8'h00;
            data_q <= 8'h00;
        end else if (wr_fire) begin
            if (awaddr_q == AXI_CMD && st_q == H_IDLE) cmd_q <= wdata_q;
            if (awaddr_q == AXI_IRQ_MASK) mask_q <= wdata_q[7:0];
            if (awaddr_q == AXI_WDATA) data_q <= wdata_q[7:0];
        end
    end

    // ------------------------------------------------------------
    // register port sequencer
    // ------------------------------------------------------------
    function automatic logic [23:0] step_op(input logic [31:0] c, input logic [2:0] s, input logic [7:0] cb);
        step_op = {c[15:0], c[7:0] & 8'h00};
        if (c[CMD_DIODE_BIT]) begin
            // export sources off before a diode is selected
            case (s)
                3'h0: step_op = {REG_EXPORT_GATE, GATE_ON};
                3'h1: step_op = {REG_VCM_EXPORT, EXPORT_OFF};
                3'h2: step_op = {REG_REF_EXPORT, EXPORT_OFF};
                default: step_op = {REG_DIODE_SEL, cb};
            endcase
        end else if (c[CMD_CLR_BIT]) begin
            step_op = {REG_OVR_CLEAR, (s == 3'h0) ? cb : 8'h00};
        end else begin
            step_op = {c[15:0], cb};
        end
    endfunction

    logic [23:0] op;
    assign op = step_op(cmd_q, step_q, clr_bits_q);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= H_IDLE;
            step_q <= 3'h0;
            nsteps_q <= 3'h0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= 16'h0;
            wd_q <= 8'h00;
            rd_q <= 8'h00;
            clr_bits_q <= 8'h00;
        end else begin
            case (st_q)
                H_IDLE: begin
                    if (cmd_go) begin
                        st_q <= H_SEQ;
                        step_q <= 3'h0;
                        clr_bits_q <= data_q;
                        nsteps_q <= wdata_q[CMD_DIODE_BIT] ? 3'h4 : wdata_q[CMD_CLR_BIT] ? 3'h2 : 3'h1;
                    end
                end
                H_SEQ: begin
                    req_q <= 1'b1;
                    we_q <= !(cmd_q[CMD_RD_BIT] && !cmd_q[CMD_DIODE_BIT] && !cmd_q[CMD_CLR_BIT]);
                    addr_q <= op[23:8];
                    wd_q <= op[7:0];
                    st_q <= H_WAIT;
                end
                H_WAIT: begin
                    if (bus.ack) begin
                        req_q <= 1'b0;
                        if (!we_q) rd_q <= bus.rdata;
                        if (step_q + 3'h1 == nsteps_q) begin
                            st_q <= H_IDLE;
                        end else begin
                            step_q <= step_q + 3'h1;
                            st_q <= H_SEQ;
                        end
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
    assign bus.req = req_q;
    assign bus.we = we_q;
    assign bus.addr = addr_q;
    assign bus.wdata = wd_q;
    assign ev_done = (st_q == H_WAIT) && bus.ack && (step_q + 3'h1 == nsteps_q);

    // ------------------------------------------------------------
    // overrange shadow from the link and interrupts
    // ------------------------------------------------------------
    assign ev_ovr = bus.link_valid && bus.ctrl_ovr;
    wire rd_stat = s_axi_arvalid && s_axi_arready && s_axi_araddr == AXI_IRQ_STAT;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_q <= 2'h0;
            ovr_q <= 8'h00;
        end else begin
            // a new event beats the read clear
            stat_q[IRQ_DONE] <= ev_done || (stat_q[IRQ_DONE] && !rd_stat);
            stat_q[IRQ_OVR] <= ev_ovr || (stat_q[IRQ_OVR] && !rd_stat);
            ovr_q <= {7'h00, ev_ovr};
        end
    end
    assign irq_o = |(stat_q & mask_q[1:0]);

    // ------------------------------------------------------------
    // axi read path
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'h0;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                AXI_CMD: s_axi_rdata <= {31'h0, st_q != H_IDLE};
                AXI_WDATA: s_axi_rdata <= cmd_q;
                AXI_RDATA: s_axi_rdata <= {24'h0, rd_q};
                AXI_IRQ_STAT: s_axi_rdata <= {30'h0, stat_q};
                AXI_IRQ_MASK: s_axi_rdata <= {24'h0, mask_q};
                AXI_OVR_SHADOW: s_axi_rdata <= {24'h0, ovr_q};
                default: s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* File: testbench/apc_monitor.sv */
// checker: port-level assertions on the link between controller and converter
`timescale 1ns/1ns
module apc_monitor (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req,
    input wire logic ack,
    input wire logic link_valid,
    input wire logic [13:0] sample,
    input wire logic ctrl_ovr,
    input wire logic k_char,
    input wire logic [13:0] sample_i,
    input wire logic [7:0] vc_overrange_i,
    input wire logic [1:0] control_bits_per_sample_i,
    input wire apc_pkg::apc_link_e link_state_o
);
    import apc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----
    // register port and link
    // ----
    a_ack_next_cycle: assert property (req && !ack |=> ack)
        else $error("access not answered in one cycle");
    a_ack_one_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (ack |-> $past(req))
        else $error("ack without request");
    // eight cycles of link up leave room for the pipe to refill after reset; the pipe keeps running through a state change
    a_sample_aligned: assert property ((link_state_o == APC_LINK_UP)[*8] |-> sample == $past(sample_i, 5))
        else $error("sample latency wrong");
    a_ovr_aligned: assert property ((link_state_o == APC_LINK_UP && $stable(control_bits_per_sample_i))[*8]
        |-> ctrl_ovr == (|$past(vc_overrange_i, 5) && control_bits_per_sample_i != 2'h0))
        else $error("overrange flag misaligned");
    a_fill_k_char: assert property (k_char |-> sample == {6'h0, K_CHAR} && link_valid)
        else $error("fill character wrong");
    a_standby_zero: assert property ((link_state_o == APC_LINK_STBY)[*3] |-> link_valid && (k_char || sample == 14'h0))
        else $error("standby sample not zero");
    a_down_no_link: assert property ((link_state_o == APC_LINK_DOWN)[*2] |-> !link_valid && !k_char)
        else $error("link kept in power-down");
endmodule

/* File: testbench/tb_top.sv */
// testbench: both ends joined, driven over AXI4-Lite and the converter inputs
`timescale 1ns/1ns
module tb_top;
    import apc_pkg::*;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic pin = 1'h0;
    logic [13:0] smp = 14'h1a5;
    logic [7:0] ovr = 8'h00;
    logic [1:0] cbps = 2'h1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, conflict;
    logic [1:0] bresp, rresp, vref;
    logic [31:0] rdata;
    apc_link_e lstate;
    int failures = 0;
    int checked = 0;
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) smp <= smp + 14'h1;
    apc_if apc_if_inst ();
    apc_device #(.PIPE_DEPTH(4)) apc_device_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(apc_if_inst.device),
        .power_down_standby_pin_i(pin), .sample_i(smp), .vc_overrange_i(ovr), .control_bits_per_sample_i(cbps),
        .vref_source_o(vref), .vref_conflict_o(conflict), .link_state_o(lstate));
    apc_host apc_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(apc_if_inst.host), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_o(irq));
    apc_monitor apc_monitor_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .req(apc_if_inst.req), .ack(apc_if_inst.ack),
        .link_valid(apc_if_inst.link_valid), .sample(apc_if_inst.sample), .ctrl_ovr(apc_if_inst.ctrl_ovr),
        .k_char(apc_if_inst.k_char), .sample_i(smp), .vc_overrange_i(ovr), .control_bits_per_sample_i(cbps),
        .link_state_o(lstate));
    // ----
    // bus tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // each valid line drops after its handshake and the task returns only once bvalid is seen, so back-to-back calls never overlap
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge clk_i);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        chk(bresp, 32'h0, "bresp");
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge clk_i);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) begin
                d = rdata;
                break;
            end
        end
    endtask
    task automatic dev_cmd(input logic [31:0] cmd, input logic [7:0] d);
        logic [31:0] b;
        axi_wr(AXI_WDATA, {24'h0, d});
        axi_wr(AXI_CMD, cmd);
        do begin
            axi_rd(AXI_CMD, b);
        end while (b !== 32'h0);
    endtask
    task automatic dev_wr(input logic [15:0] a, input logic [7:0] d);
        dev_cmd((32'h1 << CMD_WR_BIT) | {16'h0, a}, d);
    endtask
    task automatic dev_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
        logic [31:0] b;
        dev_cmd((32'h1 << CMD_RD_BIT) | {16'h0, a}, 8'h00);
        axi_rd(AXI_RDATA, b);
        chk(b[7:0], exp, what);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        logic [31:0] d;
        axi_rd(AXI_IRQ_STAT, d);
        chk(d, 32'h0, "irq status");
        chk(apc_if_inst.link_valid, 1'h1, "link up");
        dev_chk(16'h1234, 8'h00, "unmapped read");
        dev_chk(REG_OVR_STATUS, 8'h00, "sticky reset");
        $display("t_reset done");
    endtask
    task automatic t_power();
        pin <= 1'h1;
        repeat (8) @(posedge clk_i);
        chk(lstate, APC_LINK_DOWN, "pin power-down");
        chk(apc_if_inst.link_valid, 1'h0, "link dropped");
        pin <= 1'h0;
        repeat (8) @(posedge clk_i);
        chk(apc_if_inst.link_valid, 1'h1, "link back");
        dev_wr(REG_PDN_CTRL_A, {6'h0, PDN_MODE_PWRDN});
        repeat (8) @(posedge clk_i);
        chk(lstate, APC_LINK_DOWN, "reg a power-down");
        dev_wr(REG_PDN_CTRL_A, 8'h00);
        dev_wr(REG_PDN_CTRL_B, {6'h0, PDN_MODE_STBY});
        repeat (8) @(posedge clk_i);
        chk(lstate, APC_LINK_STBY, "reg b standby");
        chk(apc_if_inst.sample, 32'h0, "zero fill");
        dev_wr(REG_STBY_FILL, 8'h80);
        repeat (4) @(posedge clk_i);
        chk(apc_if_inst.k_char, 1'h1, "k fill");
        dev_chk(REG_STBY_FILL, 8'h80, "fill readback");
        dev_wr(REG_STBY_FILL, 8'h00);
        dev_wr(REG_PDN_CTRL_B, 8'h1 << PIN_FUNC_BIT);
        pin <= 1'h1;
        repeat (8) @(posedge clk_i);
        chk(lstate, APC_LINK_STBY, "pin standby");
        pin <= 1'h0;
        dev_wr(REG_PDN_CTRL_B, 8'h00);
        $display("t_power done");
    endtask
    task automatic t_diode();
        dev_cmd(32'h1 << CMD_DIODE_BIT, DIODE_SMALL);
        chk(vref, 2'h1, "small diode");
        dev_chk(REG_EXPORT_GATE, GATE_ON, "gate");
        dev_chk(REG_VCM_EXPORT, EXPORT_OFF, "vcm off");
        dev_chk(REG_REF_EXPORT, EXPORT_OFF, "ref off");
        dev_cmd(32'h1 << CMD_DIODE_BIT, DIODE_LARGE);
        chk({vref, conflict}, 3'h4, "large diode");
        dev_wr(REG_REF_EXPORT, 8'h01);
        chk(conflict, 1'h1, "two exports");
        dev_wr(REG_REF_EXPORT, EXPORT_OFF);
        dev_wr(REG_DIODE_SEL, DIODE_OFF);
        chk(vref, 2'h0, "diode off");
        $display("t_diode done");
    endtask
    task automatic t_ovr();
        logic [31:0] d;
        logic a;
        axi_wr(AXI_IRQ_MASK, 32'h0);
        axi_rd(AXI_IRQ_STAT, d);
        ovr <= 8'h05;
        @(posedge clk_i);
        ovr <= 8'h00;
        repeat (10) @(posedge clk_i);
        a = irq;
        axi_wr(AXI_IRQ_MASK, 32'h3);
        repeat (2) @(posedge clk_i);
        chk(a ^ irq, 1'h1, "mask gates irq");
        axi_rd(AXI_IRQ_STAT, d);
        chk(d[IRQ_OVR], 1'h1, "ovr event");
        repeat (2) @(posedge clk_i);
        chk(irq, 1'h0, "irq cleared");
        dev_chk(REG_OVR_STATUS, 8'h05, "sticky set");
        dev_chk(REG_OVR_STATUS, 8'h05, "sticky holds");
        dev_cmd(32'h1 << CMD_CLR_BIT, 8'h01);
        dev_chk(REG_OVR_STATUS, 8'h04, "one bit cleared");
        cbps <= 2'h0;
        ovr <= 8'h80;
        @(posedge clk_i);
        ovr <= 8'h00;
        repeat (10) @(posedge clk_i);
        dev_chk(REG_OVR_STATUS, 8'h84, "top converter");
        axi_rd(AXI_IRQ_STAT, d);
        chk(d[IRQ_OVR], 1'h0, "no control bit");
        cbps <= 2'h1;
        $display("t_ovr done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'h1;
        @(posedge clk_i);
        t_reset();
        t_power();
        t_diode();
        t_ovr();
        conclude();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        failures++;
        conclude();
    end
endmodule
